//--- verilog/tic_pkg.sv
// package: register map, field positions and timing of the time interval counter
package tic_pkg;
    localparam logic [7:0] TIC_ADDR_CONTROL = 8'ha1;
    localparam logic [7:0] TIC_ADDR_FRACTION = 8'ha2;
    localparam logic [7:0] TIC_ADDR_ONE_HZ = 8'ha3;
    localparam logic [7:0] TIC_ADDR_SIXTY_S = 8'ha4;
    localparam logic [7:0] TIC_ADDR_HOUR = 8'ha5;
    localparam logic [7:0] TIC_ADDR_TARGET = 8'ha6;
    localparam int TIC_BIT_CLOCK_ON = 0;
    localparam int TIC_BIT_RUN_ENABLE = 1;
    localparam int TIC_BIT_MATCH_FLAG = 2;
    localparam int TIC_BIT_ONE_SHOT = 3;
    localparam int TIC_BIT_BASE_LO = 4;
    localparam int TIC_BIT_BASE_HI = 5;
    localparam int TIC_BIT_DAY_WRAP = 6;
    localparam logic [7:0] TIC_RESET_VALUE = 8'h00;
    localparam logic [7:0] TIC_FRACTION_MAX = 8'h7f;
    localparam logic [7:0] TIC_SIXTY_MAX = 8'h3b;
    localparam logic [7:0] TIC_DAY_HOUR_MAX = 8'h17;
    localparam logic [7:0] TIC_FULL_HOUR_MAX = 8'hff;
    localparam logic [15:0] TIC_WAKE_VECTOR = 16'h0053;
    localparam int TIC_OSC_HZ = 32768;
    localparam int TIC_FRACTION_HZ = 128;
    localparam int TIC_OSC_PER_FRACTION = TIC_OSC_HZ / TIC_FRACTION_HZ;
    typedef enum logic [1:0] {
        TIC_BASE_FRACTION,
        TIC_BASE_SECOND,
        TIC_BASE_MINUTE,
        TIC_BASE_HOUR
    } tic_base_e;
endpackage : tic_pkg

//--- verilog/tic_prescaler.sv
// oscillator synchroniser and divider giving the 1/128 second tick
`timescale 1ns/10ps
module tic_prescaler #(
    parameter int DIVIDE = tic_pkg::TIC_OSC_PER_FRACTION
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic rc_osc,
    input wire logic run,
    output logic fraction_tick
);
    import tic_pkg::*;

    localparam int CW = (DIVIDE > 1) ? $clog2(DIVIDE) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIVIDE - 1);

    // a divide of one would need a tick on every oscillator edge with no idle count
    if (DIVIDE < 2) begin : g_bad_divide
        $error("tic_prescaler: DIVIDE must be at least 2");
    end

    logic osc_meta_q;
    logic osc_sync_q;
    logic osc_prev_q;
    logic [CW-1:0] div_q;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            osc_meta_q <= 1'b0;
            osc_sync_q <= 1'b0;
            osc_prev_q <= 1'b0;
        end else begin
            osc_meta_q <= rc_osc;
            osc_sync_q <= osc_meta_q;
            osc_prev_q <= osc_sync_q;
        end
    end

    wire osc_rise = osc_sync_q & ~osc_prev_q;

    // divider held at zero while stopped so every start gives a full first tick
    always_ff @(posedge ref_clk) begin
        if (reset || !run) begin
            div_q <= '0;
            fraction_tick <= 1'b0;
        end else begin
            fraction_tick <= osc_rise && (div_q == LAST);
            if (osc_rise) begin
                div_q <= (div_q == LAST) ? '0 : div_q + 1'b1;
            end
        end
    end
endmodule : tic_prescaler

//--- verilog/tic_counter.sv
// time interval counter: time-of-day chain, interval counter and register port
`timescale 1ns/10ps
// Contract
// - fraction counts 0..127 per 1/128 s, carries
// - seconds count 0..59, carry into minutes
// - minutes count 0..59, carry into hours
// - day-wrap bit picks hour wrap 23 or 255
// - base field picks interval counter tick
// - interval equal target sets sticky match flag
// - flag with enable interrupts and wakes power-down
// - one-shot match clears interval run enable
// - otherwise counter reloads and counts again
// - run enable bit gates interval counter
// - clock-on gates counters; off restores written values
// - time registers writable while clock off
// - counters run from oscillator, also in power-down
// - all registers reset zero, control bit 7 reserved
module tic_counter #(
    parameter int OSC_DIVIDE = tic_pkg::TIC_OSC_PER_FRACTION
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic rc_osc,
    input wire logic power_down,
    input wire logic interrupt_enable,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    output logic interrupt_request,
    output logic wake_request,
    output logic [15:0] wake_vector
);
    import tic_pkg::*;

    // the prescaler cannot serve a divide below two
    if (OSC_DIVIDE < 2) begin : g_bad_divide
        $error("tic_counter: OSC_DIVIDE must be at least 2");
    end

    function automatic logic [7:0] inc_wrap(input logic [7:0] value, input logic [7:0] limit);
        inc_wrap = (value >= limit) ? 8'h00 : value + 8'h01;
    endfunction : inc_wrap

    logic [7:0] control_q;
    logic [7:0] fraction_q;
    logic [7:0] one_hz_q;
    logic [7:0] sixty_s_q;
    logic [7:0] hour_q;
    logic [7:0] target_q;
    logic [7:0] interval_timer_q;
    logic [7:0] fraction_w_q;
    logic [7:0] one_hz_w_q;
    logic [7:0] sixty_s_w_q;
    logic [7:0] hour_w_q;
    logic fraction_tick;

    wire timebase_clock_on = control_q[TIC_BIT_CLOCK_ON];
    wire interval_run_enable = control_q[TIC_BIT_RUN_ENABLE];
    wire interval_match_flag = control_q[TIC_BIT_MATCH_FLAG];
    wire one_shot_select = control_q[TIC_BIT_ONE_SHOT];
    wire day_wrap_select = control_q[TIC_BIT_DAY_WRAP];
    tic_base_e interval_base;
    assign interval_base = tic_base_e'({control_q[TIC_BIT_BASE_HI], control_q[TIC_BIT_BASE_LO]});

    wire wr_control = sfr_wr && (sfr_addr == TIC_ADDR_CONTROL);
    wire wr_fraction = sfr_wr && (sfr_addr == TIC_ADDR_FRACTION);
    wire wr_one_hz = sfr_wr && (sfr_addr == TIC_ADDR_ONE_HZ);
    wire wr_sixty_s = sfr_wr && (sfr_addr == TIC_ADDR_SIXTY_S);
    wire wr_hour = sfr_wr && (sfr_addr == TIC_ADDR_HOUR);
    wire wr_target = sfr_wr && (sfr_addr == TIC_ADDR_TARGET);

    // oscillator keeps running in power-down; only the clock-on bit stops it
    tic_prescaler #(
        .DIVIDE(OSC_DIVIDE)
    ) u_prescaler (
        .ref_clk(ref_clk),
        .reset(reset),
        .rc_osc(rc_osc),
        .run(timebase_clock_on),
        .fraction_tick(fraction_tick)
    );

    wire [7:0] hour_limit = day_wrap_select ? TIC_DAY_HOUR_MAX : TIC_FULL_HOUR_MAX;
    wire tick_fraction = fraction_tick && timebase_clock_on;
    wire tick_second = tick_fraction && (fraction_q >= TIC_FRACTION_MAX);
    wire tick_minute = tick_second && (one_hz_q >= TIC_SIXTY_MAX);
    wire tick_hour = tick_minute && (sixty_s_q >= TIC_SIXTY_MAX);

    logic base_tick;
    always_comb begin
        unique case (interval_base)
            TIC_BASE_FRACTION: base_tick = tick_fraction;
            TIC_BASE_SECOND: base_tick = tick_second;
            TIC_BASE_MINUTE: base_tick = tick_minute;
            TIC_BASE_HOUR: base_tick = tick_hour;
        endcase
    end

    wire [7:0] interval_next = interval_timer_q + 8'h01;
    wire interval_step = base_tick && interval_run_enable;
    wire match_event = interval_step && (interval_next == target_q);
    wire run_rise = wr_control && sfr_wdata[TIC_BIT_RUN_ENABLE] && !interval_run_enable;

    // last written time values, restored whenever the clock is off
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            fraction_w_q <= TIC_RESET_VALUE;
            one_hz_w_q <= TIC_RESET_VALUE;
            sixty_s_w_q <= TIC_RESET_VALUE;
            hour_w_q <= TIC_RESET_VALUE;
        end else if (!timebase_clock_on) begin
            if (wr_fraction) begin
                fraction_w_q <= sfr_wdata;
            end
            if (wr_one_hz) begin
                one_hz_w_q <= sfr_wdata;
            end
            if (wr_sixty_s) begin
                sixty_s_w_q <= sfr_wdata;
            end
            if (wr_hour) begin
                hour_w_q <= sfr_wdata;
            end
        end
    end

    // writes while running are ignored so a carry can never be torn
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            fraction_q <= TIC_RESET_VALUE;
            one_hz_q <= TIC_RESET_VALUE;
            sixty_s_q <= TIC_RESET_VALUE;
            hour_q <= TIC_RESET_VALUE;
        end else if (!timebase_clock_on) begin
            fraction_q <= wr_fraction ? sfr_wdata : fraction_w_q;
            one_hz_q <= wr_one_hz ? sfr_wdata : one_hz_w_q;
            sixty_s_q <= wr_sixty_s ? sfr_wdata : sixty_s_w_q;
            hour_q <= wr_hour ? sfr_wdata : hour_w_q;
        end else begin
            if (tick_fraction) begin
                fraction_q <= inc_wrap(fraction_q, TIC_FRACTION_MAX);
            end
            if (tick_second) begin
                one_hz_q <= inc_wrap(one_hz_q, TIC_SIXTY_MAX);
            end
            if (tick_minute) begin
                sixty_s_q <= inc_wrap(sixty_s_q, TIC_SIXTY_MAX);
            end
            if (tick_hour) begin
                hour_q <= inc_wrap(hour_q, hour_limit);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            target_q <= TIC_RESET_VALUE;
        end else if (wr_target) begin
            target_q <= sfr_wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            interval_timer_q <= TIC_RESET_VALUE;
        end else if (run_rise || match_event) begin
            interval_timer_q <= 8'h00;
        end else if (interval_step) begin
            interval_timer_q <= interval_next;
        end
    end

    // match flag: a hardware set in the same cycle as a software clear wins
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            control_q <= TIC_RESET_VALUE;
        end else begin
            if (wr_control) begin
                control_q[6:0] <= sfr_wdata[6:0];
            end
            control_q[7] <= 1'b0;
            if (match_event) begin
                control_q[TIC_BIT_MATCH_FLAG] <= 1'b1;
                if (one_shot_select) begin
                    control_q[TIC_BIT_RUN_ENABLE] <= 1'b0;
                end
            end
        end
    end

    always_comb begin
        sfr_hit = 1'b1;
        unique case (sfr_addr)
            TIC_ADDR_CONTROL: sfr_rdata = control_q;
            TIC_ADDR_FRACTION: sfr_rdata = fraction_q;
            TIC_ADDR_ONE_HZ: sfr_rdata = one_hz_q;
            TIC_ADDR_SIXTY_S: sfr_rdata = sixty_s_q;
            TIC_ADDR_HOUR: sfr_rdata = hour_q;
            TIC_ADDR_TARGET: sfr_rdata = target_q;
            default: begin
                sfr_rdata = 8'h00;
                sfr_hit = 1'b0;
            end
        endcase
        if (!sfr_rd) begin
            sfr_rdata = 8'h00;
        end
    end

    assign interrupt_request = interval_match_flag && interrupt_enable;
    assign wake_request = interrupt_request && power_down;
    assign wake_vector = TIC_WAKE_VECTOR;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence s_match;
        match_event && !wr_control;
    endsequence

    sequence s_run_start;
        run_rise;
    endsequence

    sequence s_flag_rise;
        !interval_match_flag ##1 interval_match_flag;
    endsequence

    sequence s_stop_hold;
        !timebase_clock_on && !sfr_wr ##1 !timebase_clock_on && !sfr_wr;
    endsequence

    AST_FLAG_SET: assert property (s_match |=> interval_match_flag)
        else $error("match flag not set after match");
    AST_ONE_SHOT: assert property ((s_match and one_shot_select) |=> !interval_run_enable)
        else $error("one-shot did not stop interval counter");
    AST_RELOAD: assert property ((s_match and !one_shot_select) |=> interval_run_enable && interval_timer_q == 8'h00)
        else $error("auto reload failed");
    AST_FLAG_STICKY: assert property (interval_match_flag && !wr_control |=> interval_match_flag)
        else $error("match flag dropped without software");
    AST_FRACTION_RANGE: assert property (timebase_clock_on |-> fraction_q <= TIC_FRACTION_MAX)
        else $error("fraction counter out of range");
    AST_SECOND_CARRY: assert property (tick_second |=> fraction_q == 8'h00)
        else $error("fraction did not wrap on carry");
    AST_MINUTE_CARRY: assert property (tick_minute |=> one_hz_q == 8'h00 && $changed(sixty_s_q))
        else $error("seconds carry into minutes wrong");
    AST_HOUR_CARRY: assert property (tick_hour && sixty_s_q == TIC_SIXTY_MAX |=> sixty_s_q == 8'h00)
        else $error("minutes carry wrong");
    AST_DAY_WRAP: assert property (tick_hour && day_wrap_select && hour_q == TIC_DAY_HOUR_MAX |=> hour_q == 8'h00)
        else $error("hour did not wrap at 23");
    AST_RUN_GATE: assert property (!interval_run_enable && !run_rise |=> $stable(interval_timer_q))
        else $error("interval counter moved while disabled");
    AST_STOP_RESTORE: assert property (!timebase_clock_on && !sfr_wr ##1 !timebase_clock_on |-> hour_q == hour_w_q)
        else $error("stopped clock did not restore hour");
    AST_WAKE: assert property (wake_request |-> power_down && interval_match_flag && interrupt_enable)
        else $error("wake without cause");

    // interval counter stepping, reload and hold
    AST_ENABLE_CLEAR: assert property (s_run_start |=> interval_timer_q == 8'h00)
        else $error("interval counter not cleared on enable");
    AST_INTERVAL_STEP: assert property (interval_step && !match_event |=>
        interval_timer_q == $past(interval_timer_q) + 8'h01)
        else $error("interval counter did not step by one");
    AST_BASE_HOLD: assert property (interval_run_enable && !base_tick |=> $stable(interval_timer_q))
        else $error("interval counter moved without selected tick");
    AST_FLAG_CAUSE: assert property (s_flag_rise |-> $past(match_event || wr_control))
        else $error("match flag set without match or write");
    AST_TARGET_WRITE: assert property (wr_target |=> target_q == $past(sfr_wdata))
        else $error("target write lost");

    // time chain holds between its own carries
    AST_FRACTION_STEP: assert property (tick_fraction && !tick_second |=>
        fraction_q == $past(fraction_q) + 8'h01)
        else $error("fraction did not step by one");
    AST_SECOND_HOLD: assert property (timebase_clock_on && !tick_second |=> $stable(one_hz_q))
        else $error("seconds moved without carry");
    AST_MINUTE_HOLD: assert property (timebase_clock_on && !tick_minute |=> $stable(sixty_s_q))
        else $error("minutes moved without carry");
    AST_HOUR_HOLD: assert property (timebase_clock_on && !tick_hour |=> $stable(hour_q))
        else $error("hours moved without carry");
    AST_FULL_HOUR_WRAP: assert property (tick_hour && !day_wrap_select && hour_q == TIC_FULL_HOUR_MAX |=>
        hour_q == 8'h00)
        else $error("hour did not wrap at 255");

    // presetting and stopping
    AST_PRESET_WRITE: assert property (!timebase_clock_on && wr_hour |=> hour_q == $past(sfr_wdata))
        else $error("preset write to hour lost");
    AST_RUN_WRITE_IGNORED: assert property (timebase_clock_on && wr_fraction && !tick_fraction |=>
        $stable(fraction_q))
        else $error("write while running changed fraction");
    AST_STOP_FREEZE: assert property (s_stop_hold |=> $stable(fraction_q))
        else $error("fraction moved while clock stopped");
    AST_RESERVED_BIT: assert property (!control_q[7])
        else $error("reserved control bit set");

    // register port and wake-up
    AST_READ_IDLE: assert property (!sfr_rd |-> sfr_rdata == 8'h00)
        else $error("read data without read strobe");
    AST_UNMAPPED: assert property (!sfr_hit |-> sfr_rdata == 8'h00)
        else $error("unmapped address returned data");
    AST_HIT_RANGE: assert property (sfr_hit |-> sfr_addr >= TIC_ADDR_CONTROL && sfr_addr <= TIC_ADDR_TARGET)
        else $error("register hit outside map");
    AST_WAKE_VECTOR: assert property (wake_request |-> wake_vector == TIC_WAKE_VECTOR)
        else $error("wake vector wrong");
endmodule : tic_counter

//--- sim/test_time_interval_counter.sv
// self-checking bench for the time interval counter register port and counting chain
`timescale 1ns/10ps
module test_time_interval_counter;
    import tic_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic rc_osc = 1'b0;
    logic power_down = 1'b0;
    logic interrupt_enable = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_rdata;
    logic sfr_hit;
    logic interrupt_request;
    logic wake_request;
    logic [15:0] wake_vector;
    int mismatches = 0;
    int n_tests = 0;

    always #10 ref_clk = ~ref_clk;

    // divide of 2 so one tick costs two oscillator pulses
    tic_counter #(.OSC_DIVIDE(2)) i_dut (
        .ref_clk(ref_clk),
        .reset(reset),
        .rc_osc(rc_osc),
        .power_down(power_down),
        .interrupt_enable(interrupt_enable),
        .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata),
        .sfr_rd(sfr_rd),
        .sfr_rdata(sfr_rdata),
        .sfr_hit(sfr_hit),
        .interrupt_request(interrupt_request),
        .wake_request(wake_request),
        .wake_vector(wake_vector)
    );

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize

    // every bus task starts just after a rising edge and leaves one idle edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge ref_clk);
        sfr_wr <= 1'b0;
        @(posedge ref_clk);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(negedge ref_clk);
        chk({8'h00, sfr_rdata}, {8'h00, exp});
        chk({15'h0, sfr_hit}, {15'h0, (a >= TIC_ADDR_CONTROL && a <= TIC_ADDR_TARGET)});
        @(posedge ref_clk);
        sfr_rd <= 1'b0;
        @(posedge ref_clk);
    endtask : rd_chk

    // oscillator stands still between calls, so counts advance only here
    task automatic tick(input int n);
        repeat (2 * n) begin
            rc_osc <= 1'b1;
            repeat (4) @(posedge ref_clk);
            rc_osc <= 1'b0;
            repeat (4) @(posedge ref_clk);
        end
    endtask : tick

    task automatic preset(input logic [7:0] f, input logic [7:0] s, input logic [7:0] m, input logic [7:0] h);
        wr(TIC_ADDR_FRACTION, f);
        wr(TIC_ADDR_ONE_HZ, s);
        wr(TIC_ADDR_SIXTY_S, m);
        wr(TIC_ADDR_HOUR, h);
    endtask : preset

    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        summarize();
    end

    initial begin
        logic [7:0] e;
        repeat (5) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        for (int a = 'ha0; a <= 'ha7; a++) begin
            rd_chk(8'(a), TIC_RESET_VALUE);
        end
        chk(wake_vector, TIC_WAKE_VECTOR);
        wr(8'ha7, 8'hff);
        wr(TIC_ADDR_CONTROL, 8'h80);
        rd_chk(TIC_ADDR_CONTROL, 8'h00);
        $display("test reset and map done");
        preset(TIC_FRACTION_MAX, TIC_SIXTY_MAX, TIC_SIXTY_MAX, TIC_DAY_HOUR_MAX);
        wr(TIC_ADDR_CONTROL, 8'h41);
        tick(1);
        rd_chk(TIC_ADDR_FRACTION, 8'h00);
        rd_chk(TIC_ADDR_ONE_HZ, 8'h00);
        rd_chk(TIC_ADDR_SIXTY_S, 8'h00);
        rd_chk(TIC_ADDR_HOUR, 8'h00);
        wr(TIC_ADDR_HOUR, 8'h05);
        rd_chk(TIC_ADDR_HOUR, 8'h00);
        wr(TIC_ADDR_CONTROL, 8'h40);
        rd_chk(TIC_ADDR_FRACTION, TIC_FRACTION_MAX);
        rd_chk(TIC_ADDR_HOUR, TIC_DAY_HOUR_MAX);
        wr(TIC_ADDR_CONTROL, 8'h01);
        tick(1);
        rd_chk(TIC_ADDR_HOUR, 8'h18);
        wr(TIC_ADDR_CONTROL, 8'h00);
        wr(TIC_ADDR_HOUR, TIC_FULL_HOUR_MAX);
        wr(TIC_ADDR_CONTROL, 8'h01);
        tick(1);
        rd_chk(TIC_ADDR_HOUR, 8'h00);
        $display("test time chain done");
        wr(TIC_ADDR_CONTROL, 8'h00);
        wr(TIC_ADDR_TARGET, 8'h03);
        interrupt_enable <= 1'b1;
        power_down <= 1'b1;
        wr(TIC_ADDR_CONTROL, 8'h03);
        for (int r = 0; r < 2; r++) begin
            tick(2);
            rd_chk(TIC_ADDR_CONTROL, 8'h03);
            @(negedge ref_clk);
            chk({15'h0, interrupt_request}, 16'h0000);
            @(posedge ref_clk);
            tick(1);
            rd_chk(TIC_ADDR_CONTROL, 8'h07);
            @(negedge ref_clk);
            chk({15'h0, interrupt_request}, 16'h0001);
            chk({15'h0, wake_request}, 16'h0001);
            @(posedge ref_clk);
            wr(TIC_ADDR_CONTROL, 8'h03);
        end
        tick(3);
        power_down <= 1'b0;
        @(negedge ref_clk);
        chk({15'h0, interrupt_request}, 16'h0001);
        chk({15'h0, wake_request}, 16'h0000);
        @(posedge ref_clk);
        interrupt_enable <= 1'b0;
        @(negedge ref_clk);
        chk({15'h0, interrupt_request}, 16'h0000);
        @(posedge ref_clk);
        $display("test auto reload done");
        wr(TIC_ADDR_CONTROL, 8'h01);
        wr(TIC_ADDR_TARGET, 8'h02);
        wr(TIC_ADDR_CONTROL, 8'h0b);
        tick(2);
        rd_chk(TIC_ADDR_CONTROL, 8'h0d);
        wr(TIC_ADDR_CONTROL, 8'h09);
        tick(3);
        rd_chk(TIC_ADDR_CONTROL, 8'h09);
        $display("test one shot done");
        // carry depth l against base b: match only when the carry reaches the base
        for (int b = 0; b < 4; b++) begin
            for (int l = 0; l < 4; l++) begin
                wr(TIC_ADDR_CONTROL, 8'h00);
                preset((l > 0) ? TIC_FRACTION_MAX : 8'h00, (l > 1) ? TIC_SIXTY_MAX : 8'h00,
                    (l > 2) ? TIC_SIXTY_MAX : 8'h00, 8'h00);
                wr(TIC_ADDR_TARGET, 8'h01);
                e = {2'b00, 2'(b), 4'h3};
                wr(TIC_ADDR_CONTROL, e);
                tick(1);
                rd_chk(TIC_ADDR_CONTROL, e | ((l >= b) ? 8'h04 : 8'h00));
            end
        end
        $display("test base select done");
        summarize();
    end
endmodule : test_time_interval_counter
